// file: rtl/fep_pkg.sv
// Purpose: constants, types and helpers for the flash fault and protection block
// Assumes: 8-bit register port, 24-bit global addresses
// Notes: protection settings load once from the boot interface
// Contract
// - set double fault flag on uncorrectable read or busy-block invalid read
// - double fault flag clears only on write of one; zero leaves it
// - single fault flag bit 0 sets on corrected or invalid read unless ignored
// - single fault flag clears only on write of one; zero has no effect
// - fault flags stored one cycle after read; software waits one instruction
// - normal mode: program-flash protection writes accepted only when region grows
// - special mode: all unreserved protection bits freely writable; the code still freezes high range size while high-range-disable is clear
// - program-flash protection loaded from configuration byte during reset sequence
// - double fault on that byte: polarity cleared, other bits set
// - program or erase of protected area refused, violation flag set
// - block erase refused if any sector of that block is protected
// - polarity and high-range-disable bits select the protection function
// - size code selects 2, 4 or 8 KB range ending at top address
// - high range size writable only while high-range-disable is set
// - normal mode: eeprom size only grows, open bit only one to zero
// - eeprom open bit zero protects size range; one disables protection
// - eeprom open bit and size loaded from configuration byte at reset
// - double fault on eeprom byte: open cleared, size bits set
// - eeprom size codes protect 32, 64, 96, 128 bytes from eeprom base
// - interrupt requested while single fault flag and its enable are set
// - while violation flag set, no command launch or write sequence
package fep_pkg;
    // register offsets
    localparam logic [4:0] OFS_CONFIG    = 5'h04;
    localparam logic [4:0] OFS_STATUS    = 5'h06;
    localparam logic [4:0] OFS_ERRSTAT   = 5'h07;
    localparam logic [4:0] OFS_PPROT     = 5'h08;
    localparam logic [4:0] OFS_EPROT     = 5'h09;
    // field positions
    localparam int ERR_SINGLE_BIT = 0;
    localparam int ERR_DOUBLE_BIT = 1;
    localparam int STAT_VIOL_BIT  = 4;
    localparam int CFG_IRQ_EN_BIT = 0;
    localparam int CFG_IGNORE_BIT = 4;
    localparam int PP_POL_BIT     = 7;
    localparam int PP_HDIS_BIT    = 5;
    localparam int PP_HS_LSB      = 3;
    localparam int EP_OPEN_BIT    = 7;
    localparam int EP_SIZE_LSB    = 0;
    // reset and fault values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PPROT_FAULT  = 8'h7f;
    localparam logic [7:0] EPROT_FAULT  = 8'h03;
    localparam logic [7:0] EPROT_MASK   = 8'h83;
    // configuration byte addresses, for the boot loader
    localparam logic [23:0] CFG_PPROT_ADDR = 24'hff_fe0c;
    localparam logic [23:0] CFG_EPROT_ADDR = 24'hff_fe0d;
    // high range bases, all ending at the top address; then eeprom base and size step
    localparam logic [23:0] HR_BASE_2K = 24'hff_f800;
    localparam logic [23:0] HR_BASE_4K = 24'hff_f000;
    localparam logic [23:0] HR_BASE_8K = 24'hff_e000;
    localparam logic [23:0] EE_BASE    = 24'h10_0000;
    localparam logic [23:0] EE_STEP    = 24'h00_0020;
    // flag store latency after a read
    localparam int FLAG_DELAY_CYC = 1;

    typedef enum logic [1:0]
    {
        FEP_OP_PROGRAM     = 2'b00,
        FEP_OP_SECT_ERASE  = 2'b01,
        FEP_OP_BLOCK_ERASE = 2'b11
    } fep_op_t;

    typedef struct packed
    {
        logic single_fix;
        logic double_err;
        logic busy_invalid;
    } fep_ecc_t;

    typedef struct packed
    {
        logic        valid;
        fep_op_t     op;
        logic [23:0] addr;
    } fep_cmd_t;

    typedef struct packed
    {
        logic       load;
        logic [7:0] pprot;
        logic       pprot_fault;
        logic [7:0] eprot;
        logic       eprot_fault;
    } fep_boot_t;

    // 10 and 11 both mean 8 KB
    function automatic logic [1:0] fep_hs_eff(input logic [1:0] hs);
        fep_hs_eff = (hs == 2'b11) ? 2'b10 : hs;
    endfunction

    function automatic logic [23:0] fep_hr_base(input logic [1:0] hs);
        case (fep_hs_eff(hs))
            2'b00:   fep_hr_base = HR_BASE_2K;
            2'b01:   fep_hr_base = HR_BASE_4K;
            default: fep_hr_base = HR_BASE_8K;
        endcase
    endfunction

    function automatic logic [23:0] fep_ee_top(input logic [1:0] eeprom_prot_size);
        fep_ee_top = EE_BASE + (24'(eeprom_prot_size) + 24'h00_0001) * EE_STEP - 24'h00_0001;
    endfunction

    // true when setting nv protects at least what od protects
    function automatic logic fep_pf_covers(input logic [7:0] nv, input logic [7:0] od);
        logic       n_pol;
        logic       n_dis;
        logic       o_none;
        logic [1:0] n_hs;
        logic [1:0] o_hs;
        n_pol  = nv[PP_POL_BIT];
        n_dis  = nv[PP_HDIS_BIT];
        o_none = od[PP_POL_BIT] & od[PP_HDIS_BIT];
        n_hs   = fep_hs_eff(nv[PP_HS_LSB +: 2]);
        o_hs   = fep_hs_eff(od[PP_HS_LSB +: 2]);
        case ({n_pol, n_dis})
            2'b01:   fep_pf_covers = 1'b1;
            2'b11:   fep_pf_covers = o_none;
            2'b10:   fep_pf_covers = o_none | ((od[PP_POL_BIT] & ~od[PP_HDIS_BIT])
                                                & (n_hs >= o_hs));
            default: fep_pf_covers = o_none | ((~od[PP_POL_BIT] & ~od[PP_HDIS_BIT])
                                                & (n_hs <= o_hs));
        endcase
    endfunction
endpackage

// file: rtl/fep_guard.sv
// Purpose: flash fault flags, protection registers and command screening
// Assumes: all inputs come from logic on clock; boot load arrives during reset sequence
// Notes: register port answers reads one cycle later, never stalls
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module fep_guard
    import fep_pkg::*;
#(
    parameter logic [23:0] PF_BASE = 24'hfe_0000,
    parameter logic [23:0] EE_TOP  = 24'h10_01ff
)
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // register port
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // chip mode
    input  wire logic       special_mode,
    // array read results
    input  wire fep_ecc_t   ecc_event,
    // configuration bytes from reset sequence
    input  wire fep_boot_t  boot,
    // command requests from the command controller
    input  wire fep_cmd_t   cmd,
    output logic            cmd_start,
    output logic            cmd_refused,
    output logic            launch_blocked,
    // interrupt request
    output logic            single_fault_irq
);

    fep_ecc_t   ecc_q;
    logic       double_fault_flag;
    logic       single_fault_flag;
    logic       protection_violation_flag;
    logic       ignore_single_fault;
    logic       single_fault_irq_enable;
    logic [7:0] pflash_protection;
    logic [7:0] eeprom_protection;
    logic [7:0] next_pprot;
    logic [7:0] next_eprot;
    logic [7:0] pp_cand;
    logic       wr_config;
    logic       wr_status;
    logic       wr_errstat;
    logic       wr_pprot;
    logic       wr_eprot;
    logic       clr_double;
    logic       clr_single;
    logic       clr_viol;
    logic       set_double;
    logic       set_single;
    logic       pf_hit;
    logic       ee_hit;
    logic       pf_addr_prot;
    logic       ee_addr_prot;
    logic       pf_any_prot;
    logic       ee_any_prot;
    logic       cmd_block;
    logic       prot_reject;

    assign wr_config  = reg_write && (reg_addr == OFS_CONFIG);
    assign wr_status  = reg_write && (reg_addr == OFS_STATUS);
    assign wr_errstat = reg_write && (reg_addr == OFS_ERRSTAT);
    assign wr_pprot   = reg_write && (reg_addr == OFS_PPROT);
    assign wr_eprot   = reg_write && (reg_addr == OFS_EPROT);
    assign clr_double = wr_errstat && reg_wdata[ERR_DOUBLE_BIT];
    assign clr_single = wr_errstat && reg_wdata[ERR_SINGLE_BIT];
    assign clr_viol   = wr_status && reg_wdata[STAT_VIOL_BIT];

    // read results held one cycle before the flags take them
    always_ff @(posedge clock)
    begin
        if (reset)
            ecc_q <= '0;
        else
            ecc_q <= ecc_event;
    end

    assign set_double = ecc_q.double_err | ecc_q.busy_invalid;
    assign set_single = ~ignore_single_fault
                        & (ecc_q.single_fix | ecc_q.busy_invalid);

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge clock)
    begin
        if (reset)
            double_fault_flag <= 1'b0;
        else if (set_double)
            double_fault_flag <= 1'b1;
        else if (clr_double)
            double_fault_flag <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            single_fault_flag <= 1'b0;
        else if (set_single)
            single_fault_flag <= 1'b1;
        else if (clr_single)
            single_fault_flag <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ignore_single_fault     <= CONFIG_RESET[CFG_IGNORE_BIT];
            single_fault_irq_enable <= CONFIG_RESET[CFG_IRQ_EN_BIT];
        end
        else if (wr_config)
        begin
            ignore_single_fault     <= reg_wdata[CFG_IGNORE_BIT];
            single_fault_irq_enable <= reg_wdata[CFG_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            single_fault_irq <= 1'b0;
        else
            single_fault_irq <= single_fault_flag & single_fault_irq_enable;
    end

    // size field frozen unless the disable bit is already set
    always_comb
    begin
        pp_cand = reg_wdata;
        if (!pflash_protection[PP_HDIS_BIT])
            pp_cand[PP_HS_LSB +: 2] = pflash_protection[PP_HS_LSB +: 2];
    end

    // reserved nonvolatile bits are kept as written; software keeps them erased
    always_comb
    begin
        next_pprot = pflash_protection;
        if (boot.load)
            next_pprot = boot.pprot_fault ? PPROT_FAULT : boot.pprot;
        else if (wr_pprot && special_mode)
            next_pprot = pp_cand;
        else if (wr_pprot && fep_pf_covers(pp_cand, pflash_protection))
            next_pprot = pp_cand;
    end

    always_comb
    begin
        next_eprot = eeprom_protection;
        if (boot.load)
        begin
            next_eprot = boot.eprot_fault ? EPROT_FAULT : (boot.eprot & EPROT_MASK);
        end
        else if (wr_eprot && special_mode)
            next_eprot = reg_wdata & EPROT_MASK;
        else if (wr_eprot)
        begin
            next_eprot[EP_OPEN_BIT] = eeprom_protection[EP_OPEN_BIT]
                                      & reg_wdata[EP_OPEN_BIT];
            if (reg_wdata[EP_SIZE_LSB +: 2] > eeprom_protection[EP_SIZE_LSB +: 2])
                next_eprot[EP_SIZE_LSB +: 2] = reg_wdata[EP_SIZE_LSB +: 2];
        end
    end

    // program flash fully protected, eeprom size range protected, until the reset sequence loads the real settings
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pflash_protection <= PPROT_FAULT;
            eeprom_protection <= EPROT_FAULT;
        end
        else
        begin
            pflash_protection <= next_pprot;
            eeprom_protection <= next_eprot;
        end
    end

    // address screening
    assign pf_hit = (cmd.addr >= PF_BASE);
    assign ee_hit = (cmd.addr >= EE_BASE) && (cmd.addr <= EE_TOP);

    always_comb
    begin
        case ({pflash_protection[PP_POL_BIT], pflash_protection[PP_HDIS_BIT]})
            2'b11:   pf_addr_prot = 1'b0;
            2'b10:   pf_addr_prot = cmd.addr >= fep_hr_base(pflash_protection[PP_HS_LSB +: 2]);
            2'b01:   pf_addr_prot = 1'b1;
            default: pf_addr_prot = cmd.addr < fep_hr_base(pflash_protection[PP_HS_LSB +: 2]);
        endcase
    end

    assign ee_addr_prot = ~eeprom_protection[EP_OPEN_BIT]
                          && (cmd.addr <= fep_ee_top(eeprom_protection[EP_SIZE_LSB +: 2]));
    assign pf_any_prot  = ~(pflash_protection[PP_POL_BIT] & pflash_protection[PP_HDIS_BIT]);
    assign ee_any_prot  = ~eeprom_protection[EP_OPEN_BIT];
    assign cmd_block    = (cmd.op == FEP_OP_BLOCK_ERASE);

    always_comb
    begin
        if (cmd_block)
            prot_reject = (pf_hit && pf_any_prot) || (ee_hit && ee_any_prot);
        else
            prot_reject = (pf_hit && pf_addr_prot) || (ee_hit && ee_addr_prot);
    end

    // command decision; a set flag stops all launches
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cmd_start   <= 1'b0;
            cmd_refused <= 1'b0;
        end
        else
        begin
            cmd_start   <= cmd.valid && !protection_violation_flag && !prot_reject;
            cmd_refused <= cmd.valid && (protection_violation_flag || prot_reject);
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            protection_violation_flag <= 1'b0;
        else if (cmd.valid && prot_reject)
            protection_violation_flag <= 1'b1;
        else if (clr_viol)
            protection_violation_flag <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            launch_blocked <= 1'b0;
        else
            launch_blocked <= next_viol_view();
    end

    // mirrors the flag's next value so the pin tracks it exactly
    function automatic logic next_viol_view();
        if (cmd.valid && prot_reject)
            next_viol_view = 1'b1;
        else if (clr_viol)
            next_viol_view = 1'b0;
        else
            next_viol_view = protection_violation_flag;
    endfunction

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (!reg_read)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                OFS_CONFIG:  reg_rdata <= {3'h0, ignore_single_fault, 3'h0,
                                           single_fault_irq_enable};
                OFS_STATUS:  reg_rdata <= {3'h0, protection_violation_flag, 4'h0};
                OFS_ERRSTAT: reg_rdata <= {6'h00, double_fault_flag, single_fault_flag};
                OFS_PPROT:   reg_rdata <= pflash_protection;
                OFS_EPROT:   reg_rdata <= eeprom_protection & EPROT_MASK;
                default:     reg_rdata <= 8'h00;
            endcase
        end
    end

    // checks
    a_double_set_delay: assert property (
        @(posedge clock) disable iff (reset)
        ecc_event.double_err |-> ##2 double_fault_flag)
        else $error("double fault not stored two edges after read");

    a_double_zero_keep: assert property (
        @(posedge clock) disable iff (reset)
        (double_fault_flag && !clr_double) |=> double_fault_flag)
        else $error("double fault flag lost without a one written");

    a_single_set_flag: assert property (
        @(posedge clock) disable iff (reset)
        (ecc_q.single_fix && !ignore_single_fault) |=> single_fault_flag)
        else $error("single fault flag not set");

    a_single_ignored_clr: assert property (
        @(posedge clock) disable iff (reset)
        (!single_fault_flag && ignore_single_fault && !ecc_q.busy_invalid)
        |=> !single_fault_flag)
        else $error("single fault recorded while ignored");

    a_single_zero_keep: assert property (
        @(posedge clock) disable iff (reset)
        (single_fault_flag && !clr_single) |=> single_fault_flag)
        else $error("single fault flag lost without a one written");

    a_pprot_only_grows: assert property (
        @(posedge clock) disable iff (reset)
        (!special_mode && !boot.load)
        |=> fep_pf_covers(pflash_protection, $past(pflash_protection)))
        else $error("program flash protection shrank in normal mode");

    a_pprot_boot_fault: assert property (
        @(posedge clock) disable iff (reset)
        (boot.load && boot.pprot_fault) |=> (pflash_protection == PPROT_FAULT))
        else $error("program flash protection not forced on boot fault");

    a_hsize_locked: assert property (
        @(posedge clock) disable iff (reset)
        (!boot.load && !pflash_protection[PP_HDIS_BIT])
        |=> $stable(pflash_protection[PP_HS_LSB +: 2]))
        else $error("high range size changed while disable clear");

    a_eopen_no_rise: assert property (
        @(posedge clock) disable iff (reset)
        (!special_mode && !boot.load && !eeprom_protection[EP_OPEN_BIT])
        |=> !eeprom_protection[EP_OPEN_BIT])
        else $error("eeprom protection removed in normal mode");

    a_eprot_boot_fault: assert property (
        @(posedge clock) disable iff (reset)
        (boot.load && boot.eprot_fault) |=> (eeprom_protection == EPROT_FAULT))
        else $error("eeprom protection not forced on boot fault");

    a_viol_refuses_cmd: assert property (
        @(posedge clock) disable iff (reset)
        (cmd.valid && protection_violation_flag) |=> (cmd_refused && !cmd_start))
        else $error("command launched with violation flag set");

    a_block_erase_pf: assert property (
        @(posedge clock) disable iff (reset)
        (cmd.valid && cmd_block && pf_hit && pf_any_prot)
        |=> (!cmd_start && protection_violation_flag))
        else $error("protected block erase not refused");

    a_irq_follows_flag: assert property (
        @(posedge clock) disable iff (reset)
        (single_fault_flag && single_fault_irq_enable) ##1 single_fault_flag
        |-> single_fault_irq)
        else $error("single fault interrupt missing");

    a_irq_off_disabled: assert property (
        @(posedge clock) disable iff (reset)
        !single_fault_irq_enable |=> !single_fault_irq)
        else $error("single fault interrupt raised while disabled");

    a_double_clear_one: assert property (
        @(posedge clock) disable iff (reset)
        (clr_double && !set_double) |=> !double_fault_flag)
        else $error("double fault flag kept after a one written");

    a_single_clear_one: assert property (
        @(posedge clock) disable iff (reset)
        (clr_single && !set_single) |=> !single_fault_flag)
        else $error("single fault flag kept after a one written");

    a_refuse_sets_viol: assert property (
        @(posedge clock) disable iff (reset)
        (cmd.valid && prot_reject)
        |=> (cmd_refused && !cmd_start && protection_violation_flag))
        else $error("protected target not refused");

    a_cmd_one_answer: assert property (
        @(posedge clock) disable iff (reset)
        !(cmd_start && cmd_refused))
        else $error("command both started and refused");

    a_launch_tracks_flag: assert property (
        @(posedge clock) disable iff (reset)
        launch_blocked == protection_violation_flag)
        else $error("launch block output differs from violation flag");

endmodule
`default_nettype wire

// file: bench/fep_boot_model.sv
// Purpose: boot source model, hands the configuration bytes to the guard
// Assumes: one load pulse in the first cycle after reset release
// Notes: bytes flip outside the pulse, so a stale value is never mistaken for a load
`timescale 1ns/1ns
`default_nettype none
module fep_boot_model
    import fep_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // configuration bytes and read faults
    input  wire logic [7:0] pprot,
    input  wire logic       pprot_fault,
    input  wire logic [7:0] eprot,
    input  wire logic       eprot_fault,
    // boot interface
    output var  fep_boot_t  boot
);
    logic sent;

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sent <= 1'b0;
            boot <= '0;
        end
        else
        begin
            sent <= 1'b1;
            // single load, then every field but load toggles
            if (sent)
                boot <= fep_boot_t'{1'b0, ~boot.pprot, ~boot.pprot_fault,
                                    ~boot.eprot, ~boot.eprot_fault};
            else
                boot <= fep_boot_t'{1'b1, pprot, pprot_fault, eprot, eprot_fault};
        end
    end
endmodule
`default_nettype wire

// file: bench/fep_guard_test.sv
// Purpose: self-checking bench for the flash fault and protection guard
// Assumes: register port as in the package map, boot model on the boot port
// Notes: protection cases run from one table covering every high range size code and eeprom size codes 0, 2 and 3
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module fep_guard_test
    import fep_pkg::*;
;
    typedef struct packed
    {
        logic        ee;
        logic [7:0]  val;
        fep_op_t     op;
        logic [23:0] addr;
        logic        refuse;
    } fep_tc_t;
    localparam fep_op_t P = FEP_OP_PROGRAM;
    localparam fep_op_t S = FEP_OP_SECT_ERASE;
    localparam fep_op_t B = FEP_OP_BLOCK_ERASE;
    localparam int N = 22;
    localparam fep_tc_t tbl [N] = '{
        '{1'b0, 8'hff, P, 24'hff_ffff, 1'b0}, '{1'b0, 8'hc7, P, 24'hff_f800, 1'b1},
        '{1'b0, 8'hc7, S, 24'hff_f7ff, 1'b0}, '{1'b0, 8'hcf, P, 24'hff_f000, 1'b1},
        '{1'b0, 8'hcf, P, 24'hff_efff, 1'b0}, '{1'b0, 8'hd7, S, 24'hff_e000, 1'b1},
        '{1'b0, 8'hd7, P, 24'hff_dfff, 1'b0}, '{1'b0, 8'hdf, P, 24'hff_e000, 1'b1},
        '{1'b0, 8'h7f, P, 24'hfe_0000, 1'b1}, '{1'b0, 8'h7f, P, 24'h00_1000, 1'b0},
        '{1'b0, 8'h47, P, 24'hff_f800, 1'b0}, '{1'b0, 8'h47, P, 24'hff_f7ff, 1'b1},
        '{1'b0, 8'hc7, B, 24'hfe_0000, 1'b1}, '{1'b0, 8'hff, B, 24'hfe_0000, 1'b0},
        '{1'b1, 8'h80, P, 24'h10_0000, 1'b0}, '{1'b1, 8'h00, P, 24'h10_001f, 1'b1},
        '{1'b1, 8'h00, S, 24'h10_0020, 1'b0}, '{1'b1, 8'h02, P, 24'h10_005f, 1'b1},
        '{1'b1, 8'h02, P, 24'h10_0060, 1'b0}, '{1'b1, 8'h03, P, 24'h10_007f, 1'b1},
        '{1'b1, 8'h03, B, 24'h10_0100, 1'b1}, '{1'b1, 8'h80, B, 24'h10_0000, 1'b0}};

    logic       clock;
    logic       reset;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic       special_mode;
    fep_ecc_t   ecc_event;
    fep_boot_t  boot;
    fep_cmd_t   cmd;
    logic       cmd_start;
    logic       cmd_refused;
    logic       launch_blocked;
    logic       single_fault_irq;
    logic       b_fault;
    int         fail_count;
    int         checks;

    fep_guard fep_guard_inst (.clock(clock), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .special_mode(special_mode), .ecc_event(ecc_event),
        .boot(boot), .cmd(cmd), .cmd_start(cmd_start), .cmd_refused(cmd_refused),
        .launch_blocked(launch_blocked), .single_fault_irq(single_fault_irq));
    // reserved bits held erased in the stored byte
    fep_boot_model fep_boot_model_inst (.clock(clock), .reset(reset), .pprot(8'hff),
        .pprot_fault(b_fault), .eprot(8'h80), .eprot_fault(b_fault), .boot(boot));

    always #2 clock = ~clock;

    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic boot_reset(input logic f);
        @(posedge clock);
        b_fault <= f;
        reset   <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic ecc(input fep_ecc_t v);
        @(posedge clock);
        ecc_event <= v;
        @(posedge clock);
        ecc_event <= '0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic docmd(input fep_op_t op, input logic [23:0] a, input logic r);
        @(posedge clock);
        cmd <= '{1'b1, op, a};
        @(posedge clock);
        cmd <= '{1'b0, op, ~a};
        #1;
        `CHK(cmd_refused, r)
        `CHK(cmd_start, ~r)
        `CHK(launch_blocked, r)
    endtask

    initial
    begin
        #40000;
        fail_count++;
        $display("watchdog expired");
        results();
    end

    initial
    begin
        clock = 1'b0;
        reset = 1'b1;
        {reg_addr, reg_wdata, reg_write, reg_read, special_mode} = '0;
        ecc_event = '0;
        cmd = '0;
        b_fault = 1'b1;
        fail_count = 0;
        checks = 0;
        boot_reset(1'b1);
        rd(OFS_PPROT, 8'h7f);
        rd(OFS_EPROT, 8'h03);
        wr(5'h1f, 8'hff);
        rd(5'h1f, 8'h00);
        $display("test boot fault done");
        boot_reset(1'b0);
        rd(OFS_PPROT, 8'hff);
        rd(OFS_EPROT, 8'h80);
        $display("test boot load done");
        // read strobe right after the event must not see the flag yet
        @(posedge clock);
        ecc_event <= '{1'b0, 1'b1, 1'b0};
        @(posedge clock);
        ecc_event <= '0;
        reg_read  <= 1'b1;
        reg_addr  <= OFS_ERRSTAT;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, 8'h00)
        rd(OFS_ERRSTAT, 8'h02);
        wr(OFS_ERRSTAT, 8'h00);
        rd(OFS_ERRSTAT, 8'h02);
        wr(OFS_ERRSTAT, 8'h02);
        rd(OFS_ERRSTAT, 8'h00);
        ecc('{1'b1, 1'b0, 1'b0});
        `CHK(single_fault_irq, 1'b0)
        wr(OFS_ERRSTAT, 8'h00);
        wr(OFS_CONFIG, 8'h01);
        rd(OFS_ERRSTAT, 8'h01);
        `CHK(single_fault_irq, 1'b1)
        wr(OFS_ERRSTAT, 8'h01);
        rd(OFS_ERRSTAT, 8'h00);
        `CHK(single_fault_irq, 1'b0)
        wr(OFS_CONFIG, 8'h10);
        ecc('{1'b1, 1'b0, 1'b0});
        rd(OFS_ERRSTAT, 8'h00);
        ecc('{1'b0, 1'b0, 1'b1});
        rd(OFS_ERRSTAT, 8'h02);
        wr(OFS_CONFIG, 8'h00);
        wr(OFS_ERRSTAT, 8'h03);
        ecc('{1'b0, 1'b0, 1'b1});
        rd(OFS_ERRSTAT, 8'h03);
        wr(OFS_ERRSTAT, 8'h03);
        $display("test fault flags done");
        wr(OFS_PPROT, 8'hdf);
        rd(OFS_PPROT, 8'hdf);
        docmd(P, 24'hff_e000, 1'b1);
        docmd(P, 24'h00_1000, 1'b1);
        rd(OFS_STATUS, 8'h10);
        wr(OFS_STATUS, 8'h10);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_PPROT, 8'hff);
        rd(OFS_PPROT, 8'hdf);
        wr(OFS_EPROT, 8'h01);
        rd(OFS_EPROT, 8'h01);
        wr(OFS_EPROT, 8'h00);
        rd(OFS_EPROT, 8'h01);
        wr(OFS_EPROT, 8'h80);
        rd(OFS_EPROT, 8'h01);
        wr(OFS_EPROT, 8'h03);
        rd(OFS_EPROT, 8'h03);
        $display("test normal mode done");
        @(posedge clock);
        special_mode <= 1'b1;
        for (int i = 0; i < N; i++)
        begin
            // size field only opens while the disable bit is set
            if (!tbl[i].ee)
                wr(OFS_PPROT, 8'hff);
            wr(tbl[i].ee ? OFS_EPROT : OFS_PPROT, tbl[i].val);
            rd(tbl[i].ee ? OFS_EPROT : OFS_PPROT, tbl[i].val);
            docmd(tbl[i].op, tbl[i].addr, tbl[i].refuse);
            wr(OFS_STATUS, 8'h10);
        end
        wr(OFS_PPROT, 8'hc7);
        wr(OFS_PPROT, 8'hd7);
        rd(OFS_PPROT, 8'hc7);
        $display("test special mode done");
        results();
    end
endmodule
`default_nettype wire
